// [logic/flash_torch_consts.vh]
// Constants of the flash and torch mode control block.
// Assumes a 10 MHz ref_clk; times are in ns, counts are derived here.
`ifndef FLASH_TORCH_CONSTS_VH
`define FLASH_TORCH_CONSTS_VH

`define CLK_PERIOD_NS 100
// Least times round up to whole cycles.
`define EN_OFF_BLANK_NS 1100000000
`define EN_OFF_BLANK_CYC \
    ((`EN_OFF_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OPEN_BLANK_NS 65000
`define OPEN_BLANK_CYC ((`OPEN_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OPEN_RETRY_NS 100000000
`define OPEN_RETRY_CYC ((`OPEN_RETRY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHORT_BLANK_NS 30000
`define SHORT_BLANK_CYC \
    ((`SHORT_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHORT_RETRY_NS 100000000
`define SHORT_RETRY_CYC \
    ((`SHORT_RETRY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Serial port address and register map.
`define SLAVE_ADDR 7'h5a
`define REG_MASTER 3'h0
`define REG_FLASH 3'h1
`define REG_TORCH 3'h2
`define REG_RESET 8'h00

// Field positions.
`define MASTER_ON_BIT 7
`define MASTER_SHORT_BIT 2
`define MASTER_OPEN_BIT 1
`define MASTER_TSD_BIT 0
`define CTRL_ENABLE_BIT 7
`define TORCH_INHIBIT_BIT 6
`define LEVEL_MSB 4

`endif

// [logic/led_fault_retry.v]
// Fault qualifier with blanking and timed retry for one LED fault kind.
// Assumes fault_seen is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module led_fault_retry #(
    parameter BLANK_CYC = 650,
    parameter RETRY_CYC = 1000000
) (
    input wire clk,
    input wire rst,
    input wire regulating,
    input wire fault_seen,
    output wire force_off
);
    localparam S_WATCH = 3'b001;
    localparam S_BLANK = 3'b010;
    localparam S_RETRY = 3'b100;
    localparam [31:0] BLANK_LAST = BLANK_CYC - 1;
    localparam [31:0] RETRY_LAST = RETRY_CYC - 1;

    reg [2:0] state_q;
    reg [31:0] cnt_q;

    // ----------------------------------------------------------------
    // Blanking and retry sequence
    // ----------------------------------------------------------------
    // The detector only counts while current flows, so a fault seen
    // with the regulator off never trips the sequence.
    always @(posedge clk) begin
        if (rst) begin
            state_q <= S_WATCH;
            cnt_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                S_WATCH: begin
                    cnt_q <= 32'h0000_0000;
                    if (regulating && fault_seen) begin
                        state_q <= S_BLANK;
                    end
                end
                S_BLANK: begin
                    if (!regulating || !fault_seen) begin
                        state_q <= S_WATCH;
                    end else if (cnt_q >= BLANK_LAST) begin
                        state_q <= S_RETRY;
                        cnt_q <= 32'h0000_0000;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                S_RETRY: begin
                    if (cnt_q >= RETRY_LAST) begin
                        state_q <= S_WATCH;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                default: begin
                    state_q <= S_WATCH;
                end
            endcase
        end
    end

    assign force_off = state_q[2];
endmodule
`default_nettype wire

// [logic/flash_torch_mode_control.v]
// Mode control of a two channel flash LED driver: enable blanking,
// flash and torch requests, inhibit, serial register port, fault retry.
// Assumes all pins are asynchronous to ref_clk and that rst is power-on.
// Contract
// - Sleep only after enable low one second
// - Enable pin high means standby, ready
// - Software on bit also enables chip
// - Undriven enable pin reads low
// - Flash starts on flash pin rising edge
// - Flash ends when pin and register low
// - Floating flash pin reads low
// - Torch starts on torch pin rising edge
// - Torch ends when pin and register low
// - Inhibit high switches flash to torch level
// - Inhibit low restores flash level
// - Open LED: 65us blank, 100ms retry
// - Serial port runs up to 3.4MHz; the 10 MHz ref_clk oversampling only keeps up with the slower bench link
// - Short LED: off, retry every 100ms
// - Serial slave answers write b4, read b5
// - Soft inhibit bit acts like inhibit pin
// - Flash current is maximum times percentage
`timescale 1ns/1ps
`default_nettype none
`include "flash_torch_consts.vh"
module flash_torch_mode_control #(
    parameter EN_OFF_CYC = `EN_OFF_BLANK_CYC,
    parameter OPEN_RETRY = `OPEN_RETRY_CYC,
    parameter SHORT_RETRY = `SHORT_RETRY_CYC
) (
    input wire ref_clk,
    input wire rst,
    input wire chip_enable_pin,
    input wire flash_request_pin,
    input wire torch_request_pin,
    input wire flash_inhibit_input,
    input wire open_detect,
    input wire short_detect,
    input wire thermal_alarm,
    input wire scl,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    output wire chip_awake,
    output wire regulator_on,
    output wire flash_active,
    output wire torch_active,
    output wire use_flash_ref,
    output wire [4:0] led_sink_a_level,
    output wire [4:0] led_sink_b_level
);
    localparam NSYNC = 9;
    localparam [NSYNC-1:0] SYNC_IDLE = 9'h030;
    localparam P_IDLE = 5'b00001;
    localparam P_ADDR = 5'b00010;
    localparam P_PTR = 5'b00100;
    localparam P_WR = 5'b01000;
    localparam P_RD = 5'b10000;
    localparam [31:0] EN_OFF_LAST = EN_OFF_CYC - 1;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    wire [NSYNC-1:0] pin_raw;
    reg [NSYNC-1:0] meta_q;
    reg [NSYNC-1:0] pin_q;
    assign pin_raw = {thermal_alarm, short_detect, open_detect, sda_in, scl,
                      flash_inhibit_input, torch_request_pin,
                      flash_request_pin, chip_enable_pin};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            // Pads hold the control pins low when undriven, while the
            // serial lines idle high on their pull-ups. Each stage starts
            // at its idle level so no false edge follows reset.
            always @(posedge ref_clk) begin
                if (rst) begin
                    meta_q[gi] <= SYNC_IDLE[gi];
                    pin_q[gi] <= SYNC_IDLE[gi];
                end else begin
                    meta_q[gi] <= pin_raw[gi];
                    pin_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    wire en_s = pin_q[0];
    wire fen_s = pin_q[1];
    wire ten_s = pin_q[2];
    wire fi_s = pin_q[3];
    wire scl_s = pin_q[4];
    wire sda_s = pin_q[5];

    reg fen_d1_q, ten_d1_q, scl_d1_q, sda_d1_q;
    always @(posedge ref_clk) begin
        if (rst) begin
            fen_d1_q <= 1'b0;
            ten_d1_q <= 1'b0;
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end else begin
            fen_d1_q <= fen_s;
            ten_d1_q <= ten_s;
            scl_d1_q <= scl_s;
            sda_d1_q <= sda_s;
        end
    end

    // ----------------------------------------------------------------
    // Registers, cleared only by power-on reset
    // ----------------------------------------------------------------
    reg soft_on_q;
    reg [7:0] flash_reg_q;
    reg [7:0] torch_reg_q;
    wire short_off, open_off;

    // ----------------------------------------------------------------
    // Chip enable with off blanking
    // ----------------------------------------------------------------
    reg awake_q;
    reg [31:0] en_low_q;
    always @(posedge ref_clk) begin
        if (rst) begin
            awake_q <= 1'b0;
            en_low_q <= 32'h0000_0000;
        end else if (en_s || soft_on_q) begin
            awake_q <= 1'b1;
            en_low_q <= 32'h0000_0000;
        end else if (en_low_q >= EN_OFF_LAST) begin
            awake_q <= 1'b0;
        end else begin
            en_low_q <= en_low_q + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // Flash and torch modes
    // ----------------------------------------------------------------
    reg flash_q, torch_q, use_flash_q, reg_on_q;
    reg [4:0] level_q;
    wire flash_reg_en = flash_reg_q[`CTRL_ENABLE_BIT];
    wire torch_reg_en = torch_reg_q[`CTRL_ENABLE_BIT];
    wire inhibit = fi_s || torch_reg_q[`TORCH_INHIBIT_BIT];
    wire flash_now = flash_q && !inhibit;

    always @(posedge ref_clk) begin
        if (rst) begin
            flash_q <= 1'b0;
            torch_q <= 1'b0;
            use_flash_q <= 1'b0;
            level_q <= 5'h00;
            reg_on_q <= 1'b0;
        end else begin
            if (!awake_q) begin
                flash_q <= 1'b0;
            end else if ((fen_s && !fen_d1_q) || flash_reg_en) begin
                flash_q <= 1'b1;
            end else if (!fen_s && !flash_reg_en) begin
                flash_q <= 1'b0;
            end
            if (!awake_q) begin
                torch_q <= 1'b0;
            end else if ((ten_s && !ten_d1_q) || torch_reg_en) begin
                torch_q <= 1'b1;
            end else if (!ten_s && !torch_reg_en) begin
                torch_q <= 1'b0;
            end
            // Inhibit drops both sinks to the torch reference and code;
            // the analog sink scales its maximum by the code.
            use_flash_q <= flash_now;
            level_q <= flash_now ? flash_reg_q[`LEVEL_MSB:0]
                                 : torch_reg_q[`LEVEL_MSB:0];
            reg_on_q <= awake_q && (flash_q || torch_q) && !open_off
                        && !short_off;
        end
    end

    assign chip_awake = awake_q;
    assign regulator_on = reg_on_q;
    assign flash_active = flash_q;
    assign torch_active = torch_q && !flash_q;
    assign use_flash_ref = use_flash_q;
    assign led_sink_a_level = level_q;
    assign led_sink_b_level = level_q;

    // ----------------------------------------------------------------
    // Fault retry sequencers
    // ----------------------------------------------------------------
    led_fault_retry #(
        .BLANK_CYC(`OPEN_BLANK_CYC),
        .RETRY_CYC(OPEN_RETRY)
    ) u_open (
        .clk(ref_clk),
        .rst(rst),
        .regulating(reg_on_q),
        .fault_seen(pin_q[6]),
        .force_off(open_off)
    );

    led_fault_retry #(
        .BLANK_CYC(`SHORT_BLANK_CYC),
        .RETRY_CYC(SHORT_RETRY)
    ) u_short (
        .clk(ref_clk),
        .rst(rst),
        .regulating(reg_on_q),
        .fault_seen(pin_q[7]),
        .force_off(short_off)
    );

    // ----------------------------------------------------------------
    // Serial register slave
    // ----------------------------------------------------------------
    // Oversampling at 10 MHz covers the bench link; full 3.4 MHz needs
    // a faster ref_clk, which only the constants would change.
    reg [4:0] phase_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg [2:0] ptr_q;
    reg oe_q;
    reg [7:0] rdata;
    wire scl_rise = scl_s && !scl_d1_q;
    wire scl_fall = !scl_s && scl_d1_q;
    wire start = scl_s && scl_d1_q && !sda_s && sda_d1_q;
    wire stop = scl_s && scl_d1_q && sda_s && !sda_d1_q;
    wire addr_hit = (sh_q[7:1] == `SLAVE_ADDR);

    always @* begin
        rdata = 8'h00;
        case (ptr_q)
            `REG_MASTER: begin
                rdata[`MASTER_ON_BIT] = soft_on_q;
                rdata[`MASTER_SHORT_BIT] = short_off;
                rdata[`MASTER_OPEN_BIT] = open_off;
                rdata[`MASTER_TSD_BIT] = pin_q[8];
            end
            `REG_FLASH: rdata = flash_reg_q;
            `REG_TORCH: rdata = torch_reg_q;
            default: rdata = 8'h00;
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            phase_q <= P_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 3'h0;
            oe_q <= 1'b0;
            soft_on_q <= 1'b0;
            flash_reg_q <= `REG_RESET;
            torch_reg_q <= `REG_RESET;
        end else if (start) begin
            phase_q <= P_ADDR;
            bit_q <= 4'h0;
            oe_q <= 1'b0;
        end else if (stop) begin
            phase_q <= P_IDLE;
            oe_q <= 1'b0;
        end else if (!phase_q[0] && scl_rise) begin
            if (bit_q < 4'h8) begin
                sh_q <= {sh_q[6:0], sda_s};
                bit_q <= bit_q + 4'h1;
            end else if (bit_q == 4'h9 && phase_q == P_RD && sda_s) begin
                phase_q <= P_IDLE;
                oe_q <= 1'b0;
            end
        end else if (!phase_q[0] && scl_fall) begin
            if (bit_q == 4'h8) begin
                bit_q <= 4'h9;
                case (phase_q)
                    P_ADDR: oe_q <= addr_hit;
                    P_RD: oe_q <= 1'b0;
                    default: oe_q <= 1'b1;
                endcase
            end else if (bit_q == 4'h9) begin
                bit_q <= 4'h0;
                oe_q <= 1'b0;
                case (phase_q)
                    P_ADDR: begin
                        if (!addr_hit) begin
                            phase_q <= P_IDLE;
                        end else if (sh_q[0]) begin
                            phase_q <= P_RD;
                            sh_q <= rdata;
                            oe_q <= ~rdata[7];
                            ptr_q <= ptr_q + 3'h1;
                        end else begin
                            phase_q <= P_PTR;
                        end
                    end
                    P_PTR: begin
                        ptr_q <= sh_q[2:0];
                        phase_q <= P_WR;
                    end
                    P_WR: begin
                        case (ptr_q)
                            `REG_MASTER: soft_on_q <= sh_q[`MASTER_ON_BIT];
                            `REG_FLASH: flash_reg_q <= sh_q;
                            `REG_TORCH: torch_reg_q <= sh_q;
                            default: soft_on_q <= soft_on_q;
                        endcase
                        ptr_q <= ptr_q + 3'h1;
                    end
                    P_RD: begin
                        sh_q <= rdata;
                        oe_q <= ~rdata[7];
                        ptr_q <= ptr_q + 3'h1;
                    end
                    default: phase_q <= P_IDLE;
                endcase
            end else if (phase_q == P_RD) begin
                oe_q <= ~sh_q[7];
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
endmodule
`default_nettype wire

// [sim/flash_torch_mode_control_sva.sv]
// Checker for the flash and torch mode control block, bound to its ports.
// Assumes the bench shortens the long counts through the same parameters.
`timescale 1ns/1ps
`default_nettype none
module flash_torch_mode_control_sva #(
    parameter EN_OFF_CYC = 50,
    parameter OPEN_RETRY = 40,
    parameter SHORT_RETRY = 40
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic chip_enable_pin,
    input wire logic flash_request_pin,
    input wire logic torch_request_pin,
    input wire logic flash_inhibit_input,
    input wire logic open_detect,
    input wire logic short_detect,
    input wire logic thermal_alarm,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic chip_awake,
    input wire logic regulator_on,
    input wire logic flash_active,
    input wire logic torch_active,
    input wire logic use_flash_ref,
    input wire logic [4:0] led_sink_a_level,
    input wire logic [4:0] led_sink_b_level
);
    localparam int OPEN_BLANK = 650;
    localparam int ORLO = OPEN_RETRY - 12;
    localparam int ORHI = OPEN_RETRY + 12;
    localparam int SRLO = SHORT_RETRY - 12;
    localparam int SRHI = SHORT_RETRY + 12;
    logic [31:0] en_low_q, open_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ------
    // How long a cause has stood; the synchroniser lag is in the margins.
    // ------
    always @(posedge ref_clk) begin
        if (rst) begin
            en_low_q <= 32'h0;
            open_q <= 32'h0;
        end else begin
            en_low_q <= chip_enable_pin ? 32'h0 : en_low_q + 32'h1;
            open_q <= (open_detect && regulator_on) ?
                open_q + 32'h1 : 32'h0;
        end
    end
    property p_reset_quiet;
        disable iff (1'h0) rst |=> !chip_awake && !flash_active &&
            !torch_active && !regulator_on && !sda_oe;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("busy after reset");
    property p_torch_yields;
        flash_active |-> !torch_active;
    endproperty
    a_torch_yields: assert property (p_torch_yields)
        else $error("torch beside flash");
    property p_inhibit_ref;
        (flash_active && flash_inhibit_input) [*6] |-> !use_flash_ref;
    endproperty
    a_inhibit_ref: assert property (p_inhibit_ref)
        else $error("inhibit ignored");
    property p_sink_match;
        led_sink_a_level == led_sink_b_level;
    endproperty
    a_sink_match: assert property (p_sink_match)
        else $error("sinks differ");
    property p_asleep_clear;
        !chip_awake [*3] |-> !flash_active && !torch_active && !regulator_on;
    endproperty
    a_asleep_clear: assert property (p_asleep_clear)
        else $error("mode while asleep");
    property p_en_blank;
        $fell(chip_awake) |-> en_low_q >= EN_OFF_CYC;
    endproperty
    a_en_blank: assert property (p_en_blank)
        else $error("slept too early");
    property p_en_wake;
        chip_enable_pin [*5] |-> chip_awake;
    endproperty
    a_en_wake: assert property (p_en_wake)
        else $error("no wake on enable");
    property p_open_blank;
        open_q <= OPEN_BLANK + 6;
    endproperty
    a_open_blank: assert property (p_open_blank)
        else $error("open not acted on");
    property p_open_retry;
        $fell(regulator_on) && open_detect |=>
            !regulator_on [*8] ##[ORLO:ORHI] regulator_on;
    endproperty
    a_open_retry: assert property (p_open_retry)
        else $error("open retry off");
    property p_short_retry;
        $fell(regulator_on) && short_detect |->
            ##[SRLO:SRHI] $rose(regulator_on);
    endproperty
    a_short_retry: assert property (p_short_retry)
        else $error("short retry off");
    property p_sda_scl_low;
        $changed(sda_oe) |-> !scl && !sda_out;
    endproperty
    a_sda_scl_low: assert property (p_sda_scl_low)
        else $error("sda moved, scl high");
    c_flash: cover property ($rose(flash_active));
    c_inhibit: cover property (flash_active && !use_flash_ref);
    c_ack: cover property ($rose(sda_oe));
    c_retry: cover property ($fell(regulator_on) && open_detect);
endmodule
bind flash_torch_mode_control flash_torch_mode_control_sva #(
    .EN_OFF_CYC(EN_OFF_CYC), .OPEN_RETRY(OPEN_RETRY),
    .SHORT_RETRY(SHORT_RETRY)) chk_i (.*);
`default_nettype wire

// [sim/host_i2c.sv]
// Serial master model of the host processor.
// Assumes a pull-up on SDA, wired in the bench; SCL is driven directly.
`timescale 1ns/1ps
`default_nettype none
module host_i2c (
    input wire logic ref_clk,
    input wire logic sda_wire,
    output var logic scl,
    output var logic sda_low
);
    // ------
    // Bit timing: 800 ns a bit, SCL low 500 ns, high 300 ns.
    // ------
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    // SDA moves a cycle after SCL falls so no false start is seen.
    task automatic bit_io(input logic b, output logic seen);
        wait_cyc(1);
        sda_low = !b;
        wait_cyc(4);
        scl = 1'h1;
        wait_cyc(3);
        seen = sda_wire;
        scl = 1'h0;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], seen);
        bit_io(1'h1, seen);
        ack = !seen;
    endtask
    // Start from idle, or a repeated start once SDA is released high.
    task automatic start_cond();
        sda_low = 1'h1;
        wait_cyc(4);
        scl = 1'h0;
    endtask
    task automatic stop_cond();
        wait_cyc(1);
        sda_low = 1'h1;
        wait_cyc(4);
        scl = 1'h1;
        wait_cyc(4);
        sda_low = 1'h0;
        wait_cyc(4);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] ptr,
        input logic [7:0] dat, output logic [2:0] ack);
        start_cond();
        put_byte(adr, ack[2]);
        put_byte(ptr, ack[1]);
        put_byte(dat, ack[0]);
        stop_cond();
    endtask
    // Pointer write without data, repeated start, one byte, then NACK.
    task automatic rd(input logic [7:0] ptr, output logic [7:0] dat,
        output logic [2:0] ack);
        logic seen;
        start_cond();
        put_byte(8'hb4, ack[2]);
        put_byte(ptr, ack[1]);
        wait_cyc(1);
        sda_low = 1'h0;
        wait_cyc(4);
        scl = 1'h1;
        wait_cyc(4);
        start_cond();
        put_byte(8'hb5, ack[0]);
        for (int i = 7; i >= 0; i--)
            bit_io(1'h1, dat[i]);
        bit_io(1'h1, seen);
        stop_cond();
    endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the flash and torch mode control block.
// Assumes host_i2c as serial master and the checker bound to the block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk, rst, chip_enable_pin, flash_request_pin;
    logic torch_request_pin, flash_inhibit_input, open_detect;
    logic short_detect, thermal_alarm;
    wire scl, sda_low, sda_out, sda_oe, chip_awake, regulator_on;
    wire flash_active, torch_active, use_flash_ref;
    wire [4:0] led_sink_a_level, led_sink_b_level;
    wire sda_wire = !(sda_low || sda_oe);
    logic [8:0] exp_q[$];
    logic [15:0] rnd = 16'hc8a6;
    logic [4:0] lvl, tl;
    logic [2:0] ack;
    logic [7:0] rdat;
    int n_mismatch = 0;
    int comparisons = 0;
    event sample;
    flash_torch_mode_control #(.EN_OFF_CYC(50), .OPEN_RETRY(40),
        .SHORT_RETRY(40)) flash_torch_mode_control_i (
        .ref_clk(ref_clk), .rst(rst), .chip_enable_pin(chip_enable_pin),
        .flash_request_pin(flash_request_pin),
        .torch_request_pin(torch_request_pin),
        .flash_inhibit_input(flash_inhibit_input),
        .open_detect(open_detect), .short_detect(short_detect),
        .thermal_alarm(thermal_alarm), .scl(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_awake(chip_awake),
        .regulator_on(regulator_on), .flash_active(flash_active),
        .torch_active(torch_active), .use_flash_ref(use_flash_ref),
        .led_sink_a_level(led_sink_a_level),
        .led_sink_b_level(led_sink_b_level));
    host_i2c host_i2c_i (.ref_clk(ref_clk), .sda_wire(sda_wire),
        .scl(scl), .sda_low(sda_low));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        comparisons++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic expect_st(input logic [8:0] want);
        tick(8);
        exp_q.push_back(want);
        -> sample;
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ------
    // Monitor: level and reference are free while no mode runs.
    // ------
    always @(sample) begin
        logic [8:0] got;
        got = {chip_awake, flash_active, torch_active, use_flash_ref,
            led_sink_a_level};
        if (!(flash_active || torch_active))
            got[5:0] = 6'h0;
        check(got, exp_q.pop_front());
    end
    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #3000000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        {chip_enable_pin, flash_request_pin, torch_request_pin} = 3'h0;
        {flash_inhibit_input, open_detect, short_detect} = 3'h0;
        rst = 1'h1;
        rnd = lfsr(rnd);
        thermal_alarm = rnd[0];
        lvl = rnd[5:1];
        tl = ~lvl;
        tick(4);
        rst = 1'h0;
        expect_st(9'h000);
        chip_enable_pin = 1'h1;
        expect_st(9'h100);
        host_i2c_i.wr(8'hb4, 8'h01, {3'h0, lvl}, ack);
        check({6'h0, ack}, 9'h007);
        host_i2c_i.wr(8'hb4, 8'h02, {3'h0, tl}, ack);
        host_i2c_i.wr(8'hb6, 8'h01, 8'h80, ack);
        check({6'h0, ack}, 9'h000);
        expect_st(9'h100);
        flash_request_pin = 1'h1;
        expect_st({4'hd, lvl});
        flash_inhibit_input = 1'h1;
        expect_st({4'hc, tl});
        flash_inhibit_input = 1'h0;
        expect_st({4'hd, lvl});
        torch_request_pin = 1'h1;
        expect_st({4'hd, lvl});
        flash_request_pin = 1'h0;
        expect_st({4'ha, tl});
        torch_request_pin = 1'h0;
        expect_st(9'h100);
        host_i2c_i.wr(8'hb4, 8'h01, {3'h4, lvl}, ack);
        expect_st({4'hd, lvl});
        host_i2c_i.wr(8'hb4, 8'h02, {3'h2, tl}, ack);
        expect_st({4'hc, tl});
        host_i2c_i.wr(8'hb4, 8'h02, {3'h0, tl}, ack);
        open_detect = 1'h1;
        tick(670);
        check({8'h0, regulator_on}, 9'h000);
        open_detect = 1'h0;
        tick(60);
        check({8'h0, regulator_on}, 9'h001);
        short_detect = 1'h1;
        tick(320);
        check({8'h0, regulator_on}, 9'h000);
        tick(40);
        check({8'h0, regulator_on}, 9'h001);
        short_detect = 1'h0;
        host_i2c_i.wr(8'hb4, 8'h01, {3'h0, lvl}, ack);
        expect_st(9'h100);
        chip_enable_pin = 1'h0;
        tick(20);
        chip_enable_pin = 1'h1;
        expect_st(9'h100);
        chip_enable_pin = 1'h0;
        tick(30);
        expect_st(9'h100);
        tick(30);
        expect_st(9'h000);
        host_i2c_i.wr(8'hb4, 8'h00, 8'h80, ack);
        expect_st(9'h100);
        host_i2c_i.rd(8'h00, rdat, ack);
        check({6'h0, ack}, 9'h007);
        check({1'h0, rdat}, {2'h1, 6'h0, thermal_alarm});
        host_i2c_i.wr(8'hb4, 8'h00, 8'h00, ack);
        tick(60);
        expect_st(9'h000);
        tick(1);
        stop_test();
    end
endmodule
`default_nettype wire
